/* rtl/sitc_core.v */
// Addressed ASCII command interpreter: name, soft-init timeout, thermistor coefficients
`timescale 1ns/1ps
`include "sitc_regs.vh"
module sitc_core #(
    parameter TICKS_SEC = `SITC_TICKS_SEC       // Clock cycles per second
) (
    input  wire               clk_sys,     // System clock, 50 MHz
    input  wire               rst_n,       // Synchronous reset, active low
    input  wire        [7:0]  my_addr,     // Own module address
    input  wire               frame_checksum_en,   // Frames carry a checksum
    input  wire               init_pin_n,  // Hardware init pin, active low
    input  wire               temp_scale,  // 0 Celsius, 1 Fahrenheit
    input  wire        [7:0]  rx_data,     // Received character
    input  wire               rx_valid,    // Character strobe
    input  wire               rx_err,      // Communication error with this character
    input  wire               tx_ready,    // Transmitter takes tx_data
    input  wire               conv_done,   // Thermistor math finished
    input  wire signed [31:0] conv_temp,   // Result, Celsius hundredths
    output wire        [7:0]  tx_data,     // Reply character
    output wire               tx_valid,    // Reply character valid
    output wire               cfg_ok,      // Configuration command granted
    output wire        [31:0] cfg_fields,  // New address, type, baud, format bytes
    output wire               conv_req,    // Start thermistor math
    output wire        [26:0] conv_res,    // Resistance in tenths of an ohm
    output wire        [31:0] conv_coef_a, // Coefficient A
    output wire        [31:0] conv_coef_b, // Coefficient B
    output wire        [31:0] conv_coef_c, // Coefficient C
    output wire               soft_open    // Soft-init window open
);
    localparam S_RX = 3'd0, S_EXEC = 3'd1, S_CONV = 3'd2, S_FMT = 3'd3, S_TXL = 3'd4, S_TXW = 3'd5;
    localparam K_NONE = 4'd0, K_NAME = 4'd1, K_RDNM = 4'd2, K_TMO = 4'd3, K_SINIT = 4'd4,
               K_CFG = 4'd5, K_GET = 4'd6, K_SET = 4'd7, K_RT = 4'd8;

    reg  [7:0]  cb_q [0:`SITC_CMD_MAX-1];
    reg  [7:0]  rb_q [0:`SITC_RPL_MAX-1];
    reg  [31:0] coef_q [0:`SITC_NUM_COEF-1];
    reg  [7:0]  name_q [0:`SITC_NAME_MAX-1];
    reg  [2:0]  name_len_q, st_q;
    reg  [4:0]  len_q, tx_len_q, tx_pos_q;
    reg         in_frame_q, tx_valid_q, cfg_ok_q, conv_req_q, soft_open_q, fmt_go_q;
    reg  [7:0]  tx_data_q, tx_sum_q, tmo_q, sec_q;
    reg  [31:0] pre_q, cfg_fields_q, ca_q, cb2_q, cc_q;
    reg  [26:0] conv_res_q;

    reg  [3:0]  kind;
    reg         silent, good;
    reg  [4:0]  n;
    reg  [7:0]  sum, tcode, tx_ch;
    reg  [23:0] hx, dg;
    reg  [26:0] res;
    reg  [1:0]  letter;
    reg  [4:0]  slot;
    integer     i;
    integer     k;
    wire        fmt_done, fmt_ovf, fmt_neg;
    wire [19:0] fmt_bcd;

    function ishex;
        input [7:0] c;
        ishex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66);
    endfunction
    function [3:0] hexv;
        input [7:0] c;
        reg   [7:0] t;
        begin
            t    = (c <= 8'h39) ? c - 8'h30 : (c[3:0] + 8'h09);
            hexv = t[3:0];
        end
    endfunction
    function [7:0] hexc;
        input [3:0] v;
        hexc = (v < 4'hA) ? {4'h3, v} : ({4'h0, v} + 8'h37);
    endfunction

    // Decode a complete frame held in cb_q
    always @* begin
        n = frame_checksum_en ? len_q - 5'd2 : len_q;
        sum = 8'h00;
        res = 27'h000_0000;
        for (k = 0; k < `SITC_CMD_MAX; k = k + 1) begin
            hx[k] = ishex(cb_q[k]);
            dg[k] = (cb_q[k] >= 8'h30) && (cb_q[k] <= 8'h39);
            if (k < n) sum = sum + cb_q[k];
            if (k >= 9 && k <= 15 && dg[k]) res = res * 27'd10 + {23'h0, cb_q[k][3:0]};
        end
        if (cb_q[14] != `SITC_CH_DOT) res = res * 27'd10;
        tcode  = {hexv(cb_q[6]), hexv(cb_q[7])};
        letter = (cb_q[4] == 8'h41) ? 2'd0 : (cb_q[4] == 8'h42) ? 2'd1 : (cb_q[4] == 8'h43) ? 2'd2 : 2'd3;
        // User types sit at 0x70..0x77, so the low three bits pick the type
        slot   = {2'b00, tcode[2:0]};
        slot   = slot * 5'd3 + {3'h0, letter};
        kind   = K_NONE;
        good   = 1'b0;
        silent = (len_q < 5'd4) || (n < 5'd4) || !hx[1] || !hx[2] || ({hexv(cb_q[1]), hexv(cb_q[2])} != my_addr)
                 || (frame_checksum_en && (!hx[n] || !hx[n+1] || {hexv(cb_q[n]), hexv(cb_q[n+1])} != sum));
        case (cb_q[0])
            `SITC_CH_TILDE: begin
                if (cb_q[3] == 8'h4F && n > 5'd4 && n <= 5'd4 + `SITC_NAME_MAX) begin
                    kind = K_NAME; good = 1'b1;
                end else if (cb_q[3] == 8'h54 && n == `SITC_LEN_TMO && hx[4] && hx[5]) begin
                    kind = K_TMO; good = ({hexv(cb_q[4]), hexv(cb_q[5])} <= `SITC_TMO_MAX);
                end else if (cb_q[3] == 8'h49 && n == `SITC_LEN_SINIT) begin
                    kind = K_SINIT; good = 1'b1;
                end
            end
            `SITC_CH_DOLLAR:
                if (cb_q[3] == 8'h4D && n == `SITC_LEN_NAMERD) begin
                    kind = K_RDNM; good = 1'b1;
                end
            `SITC_CH_PCT:
                if (n == `SITC_LEN_CFG && (&hx[10:3])) begin
                    kind = K_CFG; good = !init_pin_n || soft_open_q;
                end
            `SITC_CH_AT: begin
                if (cb_q[3] == 8'h47 && n == `SITC_LEN_GET && cb_q[5] == 8'h54 && hx[6] && hx[7])
                    kind = K_GET;
                else if (cb_q[3] == 8'h53 && n == `SITC_LEN_SET && cb_q[5] == 8'h54 && hx[6] && hx[7]
                         && cb_q[8] == 8'h43 && (&hx[16:9]))
                    kind = K_SET;
                else if (cb_q[3] == 8'h52 && cb_q[4] == 8'h54 && cb_q[5] == 8'h54 && n == `SITC_LEN_RT && hx[6]
                         && hx[7] && cb_q[8] == 8'h52 && (&dg[13:9]) && dg[15] && (dg[14] || cb_q[14] == `SITC_CH_DOT))
                    kind = K_RT;
                good = (tcode >= `SITC_TYPE_BASE) && (tcode < `SITC_TYPE_BASE + `SITC_NUM_TYPES)
                       && (letter != 2'd3 || kind == K_RT);
            end
            default: kind = K_NONE;
        endcase
        if (kind == K_NONE) silent = 1'b1;
        tx_ch = `SITC_CH_CR;
        if (tx_pos_q < tx_len_q) tx_ch = rb_q[tx_pos_q[3:0]];
        else if (frame_checksum_en && tx_pos_q == tx_len_q) tx_ch = hexc(tx_sum_q[7:4]);
        else if (frame_checksum_en && tx_pos_q == tx_len_q + 5'd1) tx_ch = hexc(tx_sum_q[3:0]);
    end

    sitc_fmt u_fmt (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .start   (fmt_go_q),
        .temp_c  (conv_temp),
        .scale   (temp_scale),
        .done_q  (fmt_done),
        .ovf_q   (fmt_ovf),
        .neg_q   (fmt_neg),
        .bcd_q   (fmt_bcd)
    );

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q <= S_RX; len_q <= 5'd0; in_frame_q <= 1'b0; tx_valid_q <= 1'b0; tx_data_q <= 8'h00;
            tx_len_q <= 5'd0; tx_pos_q <= 5'd0; tx_sum_q <= 8'h00; cfg_ok_q <= 1'b0; conv_req_q <= 1'b0;
            cfg_fields_q <= 32'h0000_0000; conv_res_q <= 27'h000_0000; fmt_go_q <= 1'b0;
            ca_q <= 32'h0000_0000; cb2_q <= 32'h0000_0000; cc_q <= 32'h0000_0000;
            tmo_q <= `SITC_TMO_RST;
            soft_open_q <= 1'b0; sec_q <= 8'h00; pre_q <= 32'h0000_0000; name_len_q <= 3'd0;
            for (i = 0; i < `SITC_NUM_COEF; i = i + 1) coef_q[i] <= 32'h0000_0000;
            for (i = 0; i < `SITC_NAME_MAX; i = i + 1) name_q[i] <= 8'h00;
        end else begin
            cfg_ok_q   <= 1'b0;
            conv_req_q <= 1'b0;
            fmt_go_q   <= 1'b0;
            if (soft_open_q) begin
                if (pre_q == TICKS_SEC - 1) begin
                    pre_q <= 32'h0000_0000;
                    sec_q <= sec_q + 8'h01;
                    if (sec_q + 8'h01 >= tmo_q) soft_open_q <= 1'b0;
                end else begin
                    pre_q <= pre_q + 32'h0000_0001;
                end
            end
            case (st_q)
                S_RX:
                    if (rx_valid) begin
                        if (rx_err) begin
                            in_frame_q <= 1'b0;
                        end else if (rx_data == `SITC_CH_TILDE || rx_data == `SITC_CH_DOLLAR
                                     || rx_data == `SITC_CH_AT || rx_data == `SITC_CH_PCT) begin
                            cb_q[0] <= rx_data; len_q <= 5'd1; in_frame_q <= 1'b1;
                        end else if (rx_data == `SITC_CH_CR && in_frame_q) begin
                            in_frame_q <= 1'b0; st_q <= S_EXEC;
                        end else if (in_frame_q) begin
                            if (len_q < `SITC_CMD_MAX) begin
                                cb_q[len_q] <= rx_data; len_q <= len_q + 5'd1;
                            end else begin
                                in_frame_q <= 1'b0;
                            end
                        end
                    end
                S_EXEC: begin
                    st_q <= silent ? S_RX : S_TXL;
                    rb_q[0] <= good ? `SITC_CH_OK : `SITC_CH_BAD;
                    rb_q[1] <= hexc(my_addr[7:4]);
                    rb_q[2] <= hexc(my_addr[3:0]);
                    tx_len_q <= 5'd3; tx_pos_q <= 5'd0; tx_sum_q <= 8'h00;
                    if (!silent && kind != K_CFG && kind != K_SINIT) soft_open_q <= 1'b0;
                    if (!silent && good) begin
                        case (kind)
                            K_NAME: begin
                                for (i = 0; i < `SITC_NAME_MAX; i = i + 1) name_q[i] <= cb_q[4+i];
                                name_len_q <= n[2:0] - 3'd4;
                            end
                            K_RDNM: begin
                                for (i = 0; i < `SITC_NAME_MAX; i = i + 1) rb_q[3+i] <= name_q[i];
                                tx_len_q <= 5'd3 + {2'b00, name_len_q};
                            end
                            K_TMO: tmo_q <= {hexv(cb_q[4]), hexv(cb_q[5])};
                            K_SINIT:
                                if (tmo_q != 8'h00) begin
                                    soft_open_q <= 1'b1; sec_q <= 8'h00; pre_q <= 32'h0000_0000;
                                end
                            K_CFG: begin
                                cfg_ok_q <= 1'b1; soft_open_q <= 1'b0;
                                cfg_fields_q <= {hexv(cb_q[3]), hexv(cb_q[4]), hexv(cb_q[5]), hexv(cb_q[6]),
                                                 hexv(cb_q[7]), hexv(cb_q[8]), hexv(cb_q[9]), hexv(cb_q[10])};
                            end
                            K_GET: begin
                                for (i = 0; i < 8; i = i + 1) rb_q[3+i] <= hexc(coef_q[slot][31-4*i -: 4]);
                                tx_len_q <= 5'd11;
                            end
                            K_SET:
                                coef_q[slot] <= {hexv(cb_q[9]), hexv(cb_q[10]), hexv(cb_q[11]), hexv(cb_q[12]),
                                                 hexv(cb_q[13]), hexv(cb_q[14]), hexv(cb_q[15]), hexv(cb_q[16])};
                            K_RT: begin
                                conv_res_q <= res; conv_req_q <= 1'b1;
                                ca_q <= coef_q[slot - {3'h0, letter}];
                                cb2_q <= coef_q[slot - {3'h0, letter} + 5'd1];
                                cc_q <= coef_q[slot - {3'h0, letter} + 5'd2];
                                st_q <= S_CONV;
                            end
                            default: st_q <= S_RX;
                        endcase
                    end
                end
                S_CONV:
                    if (conv_done) begin
                        fmt_go_q <= 1'b1; st_q <= S_FMT;
                    end
                S_FMT:
                    if (fmt_done) begin
                        if (fmt_ovf) rb_q[0] <= `SITC_CH_BAD;
                        rb_q[3] <= fmt_neg ? `SITC_CH_MINUS : `SITC_CH_PLUS;
                        rb_q[4] <= {4'h3, fmt_bcd[19:16]};
                        rb_q[5] <= {4'h3, fmt_bcd[15:12]};
                        rb_q[6] <= {4'h3, fmt_bcd[11:8]};
                        rb_q[7] <= `SITC_CH_DOT;
                        rb_q[8] <= {4'h3, fmt_bcd[7:4]};
                        rb_q[9] <= {4'h3, fmt_bcd[3:0]};
                        tx_len_q <= fmt_ovf ? 5'd3 : 5'd10;
                        st_q <= S_TXL;
                    end
                S_TXL: begin
                    tx_data_q <= tx_ch; tx_valid_q <= 1'b1; st_q <= S_TXW;
                end
                S_TXW:
                    if (tx_ready) begin
                        tx_valid_q <= 1'b0;
                        if (tx_pos_q < tx_len_q) tx_sum_q <= tx_sum_q + tx_data_q;
                        if (tx_data_q == `SITC_CH_CR) begin
                            st_q <= S_RX;
                        end else begin
                            tx_pos_q <= tx_pos_q + 5'd1; st_q <= S_TXL;
                        end
                    end
                default: st_q <= S_RX;
            endcase
        end
    end

    assign tx_data     = tx_data_q;
    assign tx_valid    = tx_valid_q;
    assign cfg_ok      = cfg_ok_q;
    assign cfg_fields  = cfg_fields_q;
    assign conv_req    = conv_req_q;
    assign conv_res    = conv_res_q;
    assign conv_coef_a = ca_q;
    assign conv_coef_b = cb2_q;
    assign conv_coef_c = cc_q;
    assign soft_open   = soft_open_q;
endmodule

/* rtl/sitc_regs.vh */
// Constants for the soft-init and thermistor command interpreter
`ifndef SITC_REGS_VH
`define SITC_REGS_VH

`define SITC_CH_TILDE    8'h7E
`define SITC_CH_DOLLAR   8'h24
`define SITC_CH_AT       8'h40
`define SITC_CH_PCT      8'h25
`define SITC_CH_CR       8'h0D
`define SITC_CH_OK       8'h21
`define SITC_CH_BAD      8'h3F
`define SITC_CH_PLUS     8'h2B
`define SITC_CH_MINUS    8'h2D
`define SITC_CH_DOT      8'h2E
`define SITC_CH_ZERO     8'h30

`define SITC_CMD_MAX     24
`define SITC_RPL_MAX     16
`define SITC_NAME_MAX    6
`define SITC_LEN_NAMERD  4
`define SITC_LEN_TMO     6
`define SITC_LEN_SINIT   4
`define SITC_LEN_CFG     11
`define SITC_LEN_GET     8
`define SITC_LEN_SET     17
`define SITC_LEN_RT      16

`define SITC_TMO_MAX     8'h3C
`define SITC_TMO_RST     8'h00
`define SITC_SCALE_C     1'b0
`define SITC_SCALE_F     1'b1

`define SITC_TYPE_BASE   8'h70
`define SITC_NUM_TYPES   8
`define SITC_NUM_COEF    24

`define SITC_CLK_NS      20
`define SITC_SEC_NS      1000000000
`define SITC_TICKS_SEC   (`SITC_SEC_NS / `SITC_CLK_NS)

`define SITC_TEMP_LIM    32'h0001_869F
`define SITC_F_OFFS      40'h00_0000_0C80

`endif

/* rtl/sitc_fmt.v */
// Scale conversion and decimal formatting of a converted temperature
`timescale 1ns/1ps
`include "sitc_regs.vh"
module sitc_fmt (
    input  wire               clk_sys,  // System clock
    input  wire               rst_n,    // Synchronous reset, active low
    input  wire               start,    // One-cycle start pulse
    input  wire signed [31:0] temp_c,   // Celsius in hundredths
    input  wire               scale,    // 0 Celsius, 1 Fahrenheit
    output reg                done_q,   // One-cycle completion pulse
    output reg                ovf_q,    // Magnitude beyond 999.99
    output reg                neg_q,    // Result negative
    output reg         [19:0] bcd_q     // Five BCD digits, hundreds first
);
    reg signed [39:0] val_d;
    reg        [39:0] mag_d;
    reg        [16:0] m_d;

    function [3:0] dig;
        input [16:0] v;
        input [16:0] p;
        reg   [16:0] q;
        begin
            q   = (v / p) % 17'd10;
            dig = q[3:0];
        end
    endfunction

    always @* begin
        val_d = {{8{temp_c[31]}}, temp_c};
        if (scale == `SITC_SCALE_F) begin
            val_d = (val_d * 40'sd9) / 40'sd5 + $signed(`SITC_F_OFFS);
        end
        mag_d = val_d[39] ? $unsigned(-val_d) : $unsigned(val_d);
        m_d   = mag_d[16:0];
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            ovf_q  <= 1'b0;
            neg_q  <= 1'b0;
            bcd_q  <= 20'h0_0000;
        end else begin
            done_q <= start;
            if (start) begin
                ovf_q <= (mag_d > {8'h00, `SITC_TEMP_LIM});
                neg_q <= val_d[39];
                bcd_q <= {dig(m_d, 17'd10000), dig(m_d, 17'd1000), dig(m_d, 17'd100),
                          dig(m_d, 17'd10), dig(m_d, 17'd1)};
            end
        end
    end
endmodule

/* sim/sitc_core_properties.sv */
// Checker for reply handshake, config grant and soft-init window of sitc_core
`timescale 1ns/1ps
module sitc_core_chk #(
    parameter TICKS_SEC = 10 // Clock cycles per second
) (
    input wire       clk_sys,    // System clock
    input wire       rst_n,      // Synchronous reset, active low
    input wire       init_pin_n, // Hardware init pin, active low
    input wire       tx_ready,   // Reply character taken
    input wire [7:0] tx_data,    // Reply character
    input wire       tx_valid,   // Reply character valid
    input wire       cfg_ok,     // Config command granted
    input wire       conv_req,   // Conversion start
    input wire       soft_open   // Soft-init window open
);
    localparam int OPEN_MAX = 60 * TICKS_SEC + 2;
    reg [31:0] open_q;
    // Length of the current soft-init window in cycles
    always @(posedge clk_sys) begin
        open_q <= (!rst_n || !soft_open) ? 32'h0000_0000 : open_q + 32'h0000_0001;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_rst_quiet;
        $rose(rst_n) |-> !tx_valid && !cfg_ok && !soft_open && !conv_req;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
    property p_tx_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("reply char not held while stalled");
    property p_tx_gap;
        tx_valid && tx_ready |=> !tx_valid;
    endproperty
    a_tx_gap: assert property (p_tx_gap) else $error("reply valid not dropped after take");
    property p_cfg_grant;
        cfg_ok |-> $past(soft_open) || !$past(init_pin_n);
    endproperty
    a_cfg_grant: assert property (p_cfg_grant) else $error("config granted without pin or window");
    property p_cfg_pulse;
        cfg_ok |=> !cfg_ok && !soft_open;
    endproperty
    a_cfg_pulse: assert property (p_cfg_pulse) else $error("window still open after config");
    property p_conv_quiet;
        conv_req |-> !tx_valid ##1 !conv_req;
    endproperty
    a_conv_quiet: assert property (p_conv_quiet) else $error("conversion request not a quiet pulse");
    property p_open_ok;
        $rose(soft_open) |-> ##[1:2] (tx_valid && tx_data == 8'h21);
    endproperty
    a_open_ok: assert property (p_open_ok) else $error("window opened without valid reply");
    property p_open_bound;
        soft_open |-> open_q <= OPEN_MAX;
    endproperty
    a_open_bound: assert property (p_open_bound) else $error("window open beyond sixty seconds");
endmodule

bind sitc_core sitc_core_chk #(.TICKS_SEC(TICKS_SEC)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .init_pin_n(init_pin_n), .tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .cfg_ok(cfg_ok), .conv_req(conv_req), .soft_open(soft_open));

/* sim/sitc_host_model.sv */
// Host model: sends command frames and collects reply characters
`timescale 1ns/1ps
module sitc_host_model (
    input  wire       clk_sys,  // System clock
    input  wire [7:0] tx_data,  // Reply character
    input  wire       tx_valid, // Reply character valid
    output reg  [7:0] rx_data,  // Command character
    output reg        rx_valid, // Character strobe
    output reg        rx_err,   // Line error on this character
    output reg        tx_ready  // Reply character accepted
);
    reg slow = 1'b0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_err = 1'b0;
        tx_ready = 1'b1;
    end
    // Frame plus carriage return, optional line error at one position
    task send(input string s, input int err_pos);
        for (int i = 0; i <= s.len(); i++) begin
            @(posedge clk_sys);
            rx_valid <= 1'b1;
            rx_data  <= (i == s.len()) ? 8'h0D : s[i];
            rx_err   <= (i == err_pos);
        end
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_err   <= 1'b0;
    endtask
    // Idle line toggles so a stale character never looks valid
    task get(output logic [127:0] r, output bit got);
        r = '0;
        got = 1'b0;
        for (int n = 0; n < 300 && !got; n++) begin
            @(posedge clk_sys);
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                if (tx_data === 8'h0D) got = 1'b1;
                else r = {r[119:0], tx_data};
            end
            rx_data  <= ~rx_data;
            tx_ready <= slow ? ~tx_ready : 1'b1;
        end
    endtask
endmodule

/* sim/tb_top.sv */
// Testbench for sitc_core: command frames in, reply text checked
`timescale 1ns/1ps
module tb_top;
    localparam TICKS = 20;
    reg               clk_sys = 1'b0;
    reg               rst_n = 1'b0;
    reg        [7:0]  my_addr = 8'h01;
    reg               init_pin_n = 1'b1;
    reg               frame_checksum_en = 1'b0;
    reg               temp_scale = 1'b0;
    reg               conv_done = 1'b0;
    reg signed [31:0] conv_temp = 32'h0000_0000;
    reg        [26:0] res_q = 27'h000_0000;
    reg        [95:0] coef_q = 96'h0000_0000_0000_0000_0000_0000;
    reg        [31:0] cfg_q = 32'h0000_0000;
    wire       [7:0]  rx_data, tx_data;
    wire              rx_valid, rx_err, tx_ready, tx_valid, cfg_ok, conv_req;
    wire       [31:0] cfg_fields, conv_coef_a, conv_coef_b, conv_coef_c;
    wire       [26:0] conv_res;
    int               err_count = 0;
    int               cmp_count = 0;
    string            lt[3] = '{"A", "B", "C"};
    string            cv[3] = '{"3A94030A", "39757ACF", "33BC73A5"};
    always #10 clk_sys = ~clk_sys;
    sitc_core #(.TICKS_SEC(TICKS)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .my_addr(my_addr),
        .frame_checksum_en(frame_checksum_en), .init_pin_n(init_pin_n), .temp_scale(temp_scale), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_err(rx_err), .tx_ready(tx_ready), .conv_done(conv_done),
        .conv_temp(conv_temp), .tx_data(tx_data), .tx_valid(tx_valid), .cfg_ok(cfg_ok),
        .cfg_fields(cfg_fields), .conv_req(conv_req), .conv_res(conv_res), .conv_coef_a(conv_coef_a),
        .conv_coef_b(conv_coef_b), .conv_coef_c(conv_coef_c), .soft_open());
    sitc_host_model host (.clk_sys(clk_sys), .tx_data(tx_data), .tx_valid(tx_valid),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err), .tx_ready(tx_ready));
    // Thermistor math stand-in answers the cycle after each request
    always @(posedge clk_sys) begin
        conv_done <= conv_req;
        if (conv_req) res_q <= conv_res;
        if (conv_req) coef_q <= {conv_coef_a, conv_coef_b, conv_coef_c};
        if (cfg_ok) cfg_q <= cfg_fields;
    end
    function automatic logic [127:0] s2v(input string s);
        logic [127:0] v;
        v = '0;
        for (int i = 0; i < s.len(); i++) v = {v[119:0], s[i]};
        return v;
    endfunction
    task cmp(input logic [128:0] a, input logic [128:0] e);
        cmp_count++;
        if (a !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask
    // Empty expected text means the device must stay silent
    task chk(input string cmd, input string exp, input int err_pos = -1);
        logic [127:0] r;
        bit got;
        host.send(cmd, err_pos);
        host.get(r, got);
        cmp({got, r}, {exp.len() != 0, s2v(exp)});
    endtask
    task do_reset;
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask
    task t_name;
        chk("~01OABCDEF", "!01");
        chk("$01M", "!01ABCDEF");
        chk("~01OABCDEFG", "");
        chk("~02OXY", "");
        chk("~01OZZ", "", 3);
        frame_checksum_en <= 1'b1;
        chk("$01MD2", "!01ABCDEF17");
        chk("$01MD3", "");
        frame_checksum_en <= 1'b0;
        chk("$01M", "!01ABCDEF");
    endtask
    task t_soft;
        chk("~01I", "!01");
        chk("%0101000700", "?01");
        chk("~01T3D", "?01");
        chk("~01T3C", "!01");
        host.slow = 1'b1;
        chk("~01I", "!01");
        chk("%0101000700", "!01");
        cmp(cfg_q, 32'h0100_0700);
        host.slow = 1'b0;
        chk("~01I", "!01");
        chk("$01M", "!01ABCDEF");
        chk("%0101000700", "?01");
        chk("~01T02", "!01");
        chk("~01I", "!01");
        repeat (50) @(posedge clk_sys);
        chk("%0101000700", "?01");
        @(posedge clk_sys);
        init_pin_n <= 1'b0;
        chk("%0101000700", "!01");
        init_pin_n <= 1'b1;
        chk("~01T00", "!01");
        chk("~01T05", "!01");
        do_reset();
        chk("~01I", "!01");
        chk("%0101000700", "?01");
    endtask
    task t_coef;
        for (int i = 0; i < 3; i++) begin
            chk($sformatf("@01S%sT70C%s", lt[i], cv[i]), "!01");
            chk($sformatf("@01S%sT77C%s", lt[i], cv[2 - i]), "!01");
        end
        for (int i = 0; i < 3; i++) begin
            chk($sformatf("@01G%sT70", lt[i]), {"!01", cv[i]});
            chk($sformatf("@01G%sT77", lt[i]), {"!01", cv[2 - i]});
        end
        chk("@01GAT78", "?01");
        chk("@01SDT70C3A94030A", "?01");
        chk("@01RTT6FR0104500", "?01");
    endtask
    task t_conv;
        @(posedge clk_sys);
        conv_temp <= 32'hFFFF_F340;
        chk("@01RTT70R0104500", "!01-032.64");
        cmp(res_q, 27'h0F_F208);
        cmp(coef_q, 96'h3A94_030A_3975_7ACF_33BC_73A5);
        conv_temp <= 32'h0000_1C5E;
        chk("@01RTT70R00801.2", "!01+072.62");
        cmp(res_q, 27'h000_1F4C);
        conv_temp <= 32'h0000_2710;
        temp_scale <= 1'b1;
        chk("@01RTT77R0104500", "!01+212.00");
        cmp(coef_q, 96'h33BC_73A5_3975_7ACF_3A94_030A);
        temp_scale <= 1'b0;
        conv_temp <= 32'h0001_86A0;
        chk("@01RTT70R0104500", "?01");
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk_sys);
        err_count++;
        results();
    end
    initial begin
        do_reset();
        t_name();
        t_soft();
        t_coef();
        t_conv();
        results();
    end
endmodule
